// ### bsc_pkg.sv
/*
  Package for the bitstream input and switch control block: mode codes,
  switch element layout, decode constants, timing counts and carriers.
  Assumes a single master clock at the rate given by clk_rate_hz below.
*/
package bsc_pkg;

  // ----------------------------------------------------------------
  // modes and clock
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BSC_MODE_SINE = 2'b00,
    BSC_MODE_DC = 2'b01,
    BSC_MODE_PULSE = 2'b10,
    BSC_MODE_EXT = 2'b11
  } bsc_mode_t;

  localparam int unsigned BSC_CLK_RATE_HZ = 20_000_000;
  localparam int unsigned BSC_SAMPLE_DIV = 16;
  localparam logic [3:0] BSC_PHASE_RST = 4'h0;
  // first sample lands on the eighth rising edge after the sync edge
  localparam logic [3:0] BSC_SYNC_PHASE = 4'h8;
  localparam logic [3:0] BSC_SAMPLE_PHASE = 4'hF;
  localparam int unsigned BSC_SYNC_SETTLE_CLKS = 400;
  localparam int unsigned BSC_SETTLE_US = 100;
  localparam int unsigned BSC_SETTLE_CLKS = BSC_CLK_RATE_HZ / 1_000_000 * BSC_SETTLE_US;

  // ----------------------------------------------------------------
  // density filter
  // ----------------------------------------------------------------
  // window of 64 samples: 16 ones = 25 %, 32 = 50 %, 48 = 75 %
  localparam int unsigned BSC_WIN_LEN = 64;
  localparam logic [6:0] BSC_WIN_MID = 7'h20;
  localparam logic [6:0] BSC_WIN_LO = 7'h10;
  localparam logic [6:0] BSC_WIN_HI = 7'h30;
  localparam logic [2:0] BSC_GAIN_MAX = 3'h6;

  // ----------------------------------------------------------------
  // switch elements, bit 0 is element one
  // ----------------------------------------------------------------
  localparam logic [4:0] BSC_SW_NONE = 5'h00;
  localparam logic [4:0] BSC_SW_DIFF = 5'h05;
  localparam logic [4:0] BSC_SW_REV = 5'h0A;
  localparam logic [4:0] BSC_SW_CMP = 5'h03;
  localparam logic [4:0] BSC_SW_CMN = 5'h0C;
  localparam logic [4:0] BSC_SW_SEP = 5'h01;
  localparam logic [4:0] BSC_SW_SEN = 5'h04;
  localparam logic [4:0] BSC_SW_SHORT = 5'h10;
  localparam logic [2:0] BSC_SWCFG_RST = 3'h0;
  localparam logic [1:0] BSC_BREAK_CLKS = 2'h2;

  typedef struct packed {
    logic element_five;
    logic element_four;
    logic element_three;
    logic element_two;
    logic element_one;
  } bsc_switch_t;

  typedef struct packed {
    logic signed [7:0] level;
    logic [2:0] gain;
  } bsc_sample_t;

endpackage : bsc_pkg

// ### bsc_ctrl.sv
/*
  Bitstream input and output switch control: the shared pin either gates
  the switch or carries a ones-density bitstream sampled every 16 clocks.
  Assumes synchronous inputs on clk; mode, gain and switch code come from
  registers held elsewhere.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - external mode bypasses generator, uses bitstream
// - bitstream sampled at one sixteenth clock
// - output proportional to density minus half
// - gain field scales output 1/1 to 1/64
// - output settles about 100 us after change
// - pulse mode disables output filter path
// - switch from config field and gate pin
// - break before make on any change
// - codes 000, 001, 010 decode
// - codes 011 to 111 decode
// - power down forces all elements open
// - shared pin function depends on mode
// - gate low opens all elements
// - gate high follows config field
// - sync rising zeroes output, sets phase
// - settled 400 clocks after sync
module bsc_ctrl
  import bsc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire bsc_mode_t mode,
  input wire logic [2:0] analog_gain,
  input wire logic [2:0] switch_config_field,
  input wire logic switch_gate_or_bitstream_pin,
  input wire logic sync_in,
  input wire logic power_down,
  input wire logic gen_valid,
  input wire logic signed [7:0] gen_level,
  output logic gen_ready,
  output bsc_switch_t switch_elements,
  output logic out_valid,
  output bsc_sample_t out_data,
  input wire logic out_ready,
  output logic filter_enable,
  output logic ext_active,
  output logic settled,
  output logic bit_taken
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] sw_decode(input logic [2:0] code);
    case (code)
      3'b000: sw_decode = BSC_SW_NONE;
      3'b001: sw_decode = BSC_SW_DIFF;
      3'b010: sw_decode = BSC_SW_REV;
      3'b011: sw_decode = BSC_SW_CMP;
      3'b100: sw_decode = BSC_SW_CMN;
      3'b101: sw_decode = BSC_SW_SEP;
      3'b110: sw_decode = BSC_SW_SEN;
      3'b111: sw_decode = BSC_SW_SHORT;
      default: sw_decode = BSC_SW_NONE;
    endcase
  endfunction : sw_decode

  function automatic logic [2:0] gain_clip(input logic [2:0] g);
    gain_clip = (g > BSC_GAIN_MAX) ? BSC_GAIN_MAX : g;
  endfunction : gain_clip

  logic ext_mode;
  assign ext_mode = (mode == BSC_MODE_EXT);
  assign ext_active = ext_mode;

  // pulse mode is the only one that runs without the output filter
  assign filter_enable = (mode != BSC_MODE_PULSE);

  // ----------------------------------------------------------------
  // switch target and break-before-make
  // ----------------------------------------------------------------
  logic [4:0] sw_target;
  logic gate_lvl;
  always_comb begin
    // in external mode the pin carries data, so it cannot gate the switch
    gate_lvl = ext_mode ? 1'b1 : switch_gate_or_bitstream_pin;
    if (power_down) begin
      sw_target = BSC_SW_NONE;
    end else if (!gate_lvl) begin
      sw_target = BSC_SW_NONE;
    end else begin
      sw_target = sw_decode(switch_config_field);
    end
  end

  typedef enum logic [1:0] {
    BSC_SW_ST_HOLD = 2'b00,
    BSC_SW_ST_BREAK = 2'b01,
    BSC_SW_ST_MAKE = 2'b10
  } bsc_sw_state_t;

  bsc_sw_state_t sw_state_q;
  logic [4:0] sw_q;
  logic [1:0] brk_cnt_q;

  // state walk: hold, break for a fixed time, then make
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sw_state_q <= BSC_SW_ST_HOLD;
    end else begin
      case (sw_state_q)
        BSC_SW_ST_HOLD: begin
          if (sw_target != sw_q) begin
            sw_state_q <= BSC_SW_ST_BREAK;
          end
        end
        BSC_SW_ST_BREAK: begin
          if (brk_cnt_q <= 2'h1) begin
            sw_state_q <= BSC_SW_ST_MAKE;
          end
        end
        BSC_SW_ST_MAKE: begin
          sw_state_q <= BSC_SW_ST_HOLD;
        end
        default: begin
          sw_state_q <= BSC_SW_ST_HOLD;
        end
      endcase
    end
  end

  // break timer, loaded as the break starts
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      brk_cnt_q <= 2'h0;
    end else if (sw_state_q == BSC_SW_ST_HOLD && sw_target != sw_q) begin
      brk_cnt_q <= BSC_BREAK_CLKS;
    end else if (sw_state_q == BSC_SW_ST_BREAK && brk_cnt_q > 2'h1) begin
      brk_cnt_q <= brk_cnt_q - 2'h1;
    end
  end

  // switch register: opened on any change, closed only from the make step
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sw_q <= BSC_SW_NONE;
    end else begin
      case (sw_state_q)
        BSC_SW_ST_HOLD: begin
          if (sw_target != sw_q) begin
            // open first, whatever the new target holds
            sw_q <= BSC_SW_NONE;
          end
        end
        BSC_SW_ST_MAKE: begin
          // a target that moved during the break is picked up here
          sw_q <= sw_target;
        end
        default: begin
          sw_q <= BSC_SW_NONE;
        end
      endcase
    end
  end
  // power-down also bypasses the sequencer so the open is immediate
  assign switch_elements = power_down ? BSC_SW_NONE : sw_q;

  // ----------------------------------------------------------------
  // sample phase and sync
  // ----------------------------------------------------------------
  logic sync_q;
  logic sync_rise;
  logic [3:0] phase_q;
  logic sample_now;

  assign sync_rise = sync_in && !sync_q;
  assign sample_now = ext_mode && (phase_q == BSC_SAMPLE_PHASE);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= sync_in;
    end
  end

  // phase counts the master clock; divider by 16 sets the bit rate
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_q <= BSC_PHASE_RST;
    end else if (ext_mode && sync_rise) begin
      phase_q <= BSC_SYNC_PHASE;
    end else begin
      phase_q <= phase_q + 4'h1;
    end
  end

  assign bit_taken = sample_now;

  // ----------------------------------------------------------------
  // density filter: moving sum of the last 64 samples
  // ----------------------------------------------------------------
  logic [BSC_WIN_LEN-1:0] win_q;
  logic [6:0] ones_q;
  logic win_clr;

  // mid-scale history means zero output after a sync
  assign win_clr = !ext_mode || sync_rise;

  always_ff @(posedge clk) begin
    if (sys_rst || win_clr) begin
      win_q <= {(BSC_WIN_LEN / 2){2'b01}};
    end else if (sample_now) begin
      win_q <= {win_q[BSC_WIN_LEN-2:0], switch_gate_or_bitstream_pin};
    end
  end

  // running count beside the window, so no 64-input adder is needed
  always_ff @(posedge clk) begin
    if (sys_rst || win_clr) begin
      ones_q <= BSC_WIN_MID;
    end else if (sample_now) begin
      ones_q <= ones_q + {6'h00, switch_gate_or_bitstream_pin} -
                {6'h00, win_q[BSC_WIN_LEN-1]};
    end
  end

  // (ones - 50 %) / 25 %, scaled so full scale reads +/-127
  function automatic logic signed [7:0] density_level(input logic [6:0] ones);
    logic signed [8:0] diff;
    logic signed [8:0] lvl;
    diff = $signed({2'b00, ones}) - $signed({2'b00, BSC_WIN_MID});
    lvl = diff * 9'sd8;
    if (ones >= BSC_WIN_HI) begin
      density_level = 8'sd127;
    end else if (ones <= BSC_WIN_LO) begin
      density_level = -8'sd127;
    end else begin
      density_level = lvl[7:0];
    end
  endfunction : density_level

  // ----------------------------------------------------------------
  // source select into the two-entry buffer
  // ----------------------------------------------------------------
  logic src_valid;
  bsc_sample_t src_data;
  logic src_ready;

  always_comb begin
    if (ext_mode) begin
      // generator is ignored; the bitstream alone drives the output
      src_valid = sample_now || sync_rise;
      // a sync pushes a zero word at once, ahead of the first new sample
      if (sync_rise) begin
        src_data.level = 8'sh00;
      end else begin
        src_data.level = density_level(ones_q);
      end
    end else begin
      src_valid = gen_valid;
      src_data.level = gen_level;
    end
    src_data.gain = gain_clip(analog_gain);
  end
  // generator is stalled by the buffer, never by a dropped word
  assign gen_ready = ext_mode ? 1'b0 : src_ready;

  bsc_sample_t buf_q [2];
  logic [1:0] cnt_q;
  logic rd_ptr_q;
  logic wr_ptr_q;
  logic push;
  logic pop;

  assign src_ready = (cnt_q != 2'h2);
  assign push = src_valid && src_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = buf_q[rd_ptr_q];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else if (push) begin
      buf_q[wr_ptr_q] <= src_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
    end
  end

  // a count, not a pointer compare, tells full from empty with 1-bit pointers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // ----------------------------------------------------------------
  // settling indication
  // ----------------------------------------------------------------
  logic [11:0] settle_q;
  logic [11:0] settle_need;
  logic signed [7:0] last_lvl_q;
  logic step_seen;

  // in external mode the level moves with every sample, so only a sync
  // restarts the count there and 400 clocks suffice; in sine and DC mode a step
  // restarts it and 100 us are needed
  assign settle_need = ext_mode ? 12'(BSC_SYNC_SETTLE_CLKS) : 12'(BSC_SETTLE_CLKS);
  assign step_seen = push && (src_data.level != last_lvl_q);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      last_lvl_q <= 8'sh00;
    end else if (push) begin
      last_lvl_q <= src_data.level;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || (ext_mode && sync_rise)) begin
      settle_q <= 12'h000;
    end else if (step_seen && filter_enable && !ext_mode) begin
      settle_q <= 12'h000;
    end else if (settle_q != 12'hFFF) begin
      settle_q <= settle_q + 12'h001;
    end
  end

  // pulse mode has no filter, so it counts as settled at once
  assign settled = !filter_enable || (settle_q >= settle_need);

endmodule : bsc_ctrl

`default_nettype wire

// ### bsc_ctrl_assertions.sv
/*
  Checker for bsc_ctrl: switch decode, break-before-make, gating,
  bitstream sampling phase and output buffer hold.
  Assumes one clock domain and the synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module bsc_ctrl_chk
  import bsc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire bsc_mode_t mode,
  input wire logic [2:0] analog_gain,
  input wire logic [2:0] switch_config_field,
  input wire logic switch_gate_or_bitstream_pin,
  input wire logic sync_in,
  input wire logic power_down,
  input wire logic gen_valid,
  input wire logic signed [7:0] gen_level,
  input wire logic gen_ready,
  input wire bsc_switch_t switch_elements,
  input wire logic out_valid,
  input wire bsc_sample_t out_data,
  input wire logic out_ready,
  input wire logic filter_enable,
  input wire logic ext_active,
  input wire logic settled,
  input wire logic bit_taken
);
  localparam logic [4:0] SWX [8] = '{5'h00, 5'h05, 5'h0A, 5'h03, 5'h0C, 5'h01, 5'h04, 5'h10};
  logic [2:0] zc_q;
  logic [4:0] gap_q;
  logic sy_q;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // cycles the switch has shown all open, saturating
  always_ff @(posedge clk) begin
    if (sys_rst || switch_elements != 5'h00) zc_q <= 3'h0;
    else if (zc_q != 3'h7) zc_q <= zc_q + 3'h1;
  end

  // 31 means no reference point yet, so the first sample is not judged
  always_ff @(posedge clk) begin
    sy_q <= sync_in;
    if (sys_rst || !ext_active) gap_q <= 5'h1F;
    else if (sync_in && !sy_q) gap_q <= 5'h00;
    else if (bit_taken) gap_q <= 5'h08;
    else if (gap_q != 5'h1F) gap_q <= gap_q + 5'h01;
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_sync_rise;
    !sync_in ##1 sync_in;
  endsequence

  a_pd_opens_all: assert property (power_down |-> switch_elements == 5'h00)
    else $error("switch closed during power down");
  a_gate_low_open: assert property (
    !ext_active && !switch_gate_or_bitstream_pin |=> switch_elements == 5'h00)
    else $error("gate low left switch closed");
  a_decode_map: assert property (
    switch_elements != 5'h00 |-> switch_elements == SWX[$past(switch_config_field)])
    else $error("switch pattern does not match code");
  a_break_first: assert property (
    switch_elements != $past(switch_elements) && $past(switch_elements) != 5'h00
    |-> switch_elements == 5'h00) else $error("switch went closed to closed");
  a_make_after_break: assert property (
    switch_elements != 5'h00 && $past(switch_elements) == 5'h00 && !$past(power_down)
    |-> zc_q >= 3'h3) else $error("make came too early");
  a_bit_phase: assert property (
    bit_taken && gap_q != 5'h1F |-> gap_q == 5'h07 || gap_q == 5'h17)
    else $error("bitstream sample off phase");
  a_bit_ext_only: assert property (bit_taken |-> ext_active)
    else $error("bit sampled outside external mode");
  a_gen_bypass: assert property (ext_active |-> !gen_ready)
    else $error("generator accepted in external mode");
  a_filter_mode: assert property (filter_enable == (mode != BSC_MODE_PULSE))
    else $error("filter enable wrong for mode");
  a_sync_unsettle: assert property ((ext_active throughout s_sync_rise) |=> !settled)
    else $error("settled right after sync");
  a_buf_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled output word changed");
endmodule : bsc_ctrl_chk

bind bsc_ctrl bsc_ctrl_chk i_chk (.*);
`default_nettype wire

// ### bsc_bitsrc.sv
/*
  Far-side model: drives the shared pin with a gate level, or in
  external mode with a ones-density bitstream of dens ones per 64 bits.
  Assumes the bench clock; dens stays below 64.
*/
`timescale 1ns/1ps
`default_nettype none
module bsc_bitsrc
  import bsc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ext_mode,
  input wire logic gate_lvl,
  input wire logic [6:0] dens,
  output logic pin
);
  logic [3:0] ph_q;
  logic [6:0] acc_q;
  // new bit every 16 clocks on the falling edge, so each bit is stable
  // around whichever rising edge the device samples
  always_ff @(negedge clk) begin
    ph_q <= sys_rst ? 4'h0 : ph_q + 4'h1;
    if (sys_rst) acc_q <= 7'h00;
    else if (ph_q == 4'hF) acc_q <= {1'b0, acc_q[5:0]} + dens;
  end
  // carry of the accumulator: exactly dens ones in any 64 bits
  assign pin = ext_mode ? acc_q[6] : gate_lvl;
endmodule : bsc_bitsrc
`default_nettype wire

// ### bsc_ctrl_tb_top.sv
/*
  Self-checking bench for bsc_ctrl: switch decode under random codes,
  gate and power down, density levels, sync settling and buffer stall.
  Assumes bsc_pkg, bsc_bitsrc and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module bsc_ctrl_tb_top
  import bsc_pkg::*;
;
  localparam logic [4:0] SWX [8] = '{5'h00, 5'h05, 5'h0A, 5'h03, 5'h0C, 5'h01, 5'h04, 5'h10};
  localparam logic [6:0] DS [6] = '{7'h08, 7'h30, 7'h28, 7'h20, 7'h1C, 7'h38};
  logic clk = 1'b0, sys_rst = 1'b1, sync_in = 1'b0, power_down = 1'b0;
  logic gen_valid = 1'b0, out_ready = 1'b1, gate_lvl = 1'b1, g, p, x;
  logic [2:0] analog_gain = 3'h0, switch_config_field = 3'h0, c;
  logic [6:0] dens = 7'h20;
  logic signed [7:0] gen_level = 8'h00;
  bsc_mode_t mode = BSC_MODE_SINE;
  logic switch_gate_or_bitstream_pin, gen_ready, out_valid, filter_enable;
  logic ext_active, settled, bit_taken;
  bsc_switch_t switch_elements;
  bsc_sample_t out_data, last_q;
  int mismatches = 0, cmp_count = 0, nbits = 0, n0;

  initial begin
    forever #25 clk = ~clk;
  end

  bsc_ctrl i_dut (.*);
  bsc_bitsrc i_src (.clk(clk), .sys_rst(sys_rst), .ext_mode(mode == BSC_MODE_EXT),
    .gate_lvl(gate_lvl), .dens(dens), .pin(switch_gate_or_bitstream_pin));

  always @(posedge clk) begin
    if (out_valid && out_ready) last_q <= out_data;
    if (bit_taken) nbits++;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tk(input int n);
    repeat (n) @(negedge clk);
  endtask : tk

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [4:0] exp_sw(input logic [2:0] cc, input logic gg, input logic pp,
    input logic xx);
    exp_sw = (pp || (!xx && !gg)) ? 5'h00 : SWX[cc];
  endfunction : exp_sw

  // level is (ones - 32) * 8 over 64 samples, clipped at 25 % and 75 %
  function automatic logic [7:0] exp_lvl(input logic [6:0] d);
    exp_lvl = d >= 7'h30 ? 8'h7F : d <= 7'h10 ? 8'h81 : 8'((int'(d) - 32) * 8);
  endfunction : exp_lvl

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  initial begin
    #2_000_000;
    mismatches++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h7573));
    tk(20);
    sys_rst <= 1'b0;
    tk(1);
    chk(switch_elements, 5'h00);
    for (int m = 0; m < 4; m++) begin
      mode <= bsc_mode_t'(m);
      tk(1);
      chk({filter_enable, ext_active, gen_ready}, {m != 2, m == 3, m != 3});
    end
    // all codes first, then random codes, gate, power down and modes
    for (int i = 0; i < 48; i++) begin
      c = i < 8 ? 3'(i) : 3'($urandom);
      g = i < 8 || $urandom % 3 != 0;
      p = i >= 8 && $urandom % 5 == 0;
      x = i >= 40;
      mode <= x ? BSC_MODE_EXT : bsc_mode_t'($urandom % 3);
      switch_config_field <= c;
      gate_lvl <= g;
      power_down <= p;
      tk(6);
      chk(switch_elements, exp_sw(c, g, p, x));
    end
    power_down <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      dens <= DS[k];
      analog_gain <= k == 0 ? 3'h7 : 3'($urandom);
      sync_in <= 1'b0;
      tk(2);
      sync_in <= 1'b1;
      tk(395);
      chk(settled, 1'b0);
      tk(10);
      chk(settled, 1'b1);
      tk(1100);
      chk(last_q, {exp_lvl(DS[k]), analog_gain > 3'h6 ? 3'h6 : analog_gain});
      n0 = nbits;
      tk(160);
      chk(nbits - n0, 10);
    end
    // stall: two words fill the buffer, then drain in order
    mode <= BSC_MODE_DC;
    tk(2);
    out_ready <= 1'b0;
    gen_valid <= 1'b1;
    gen_level <= 8'h5A;
    tk(1);
    gen_level <= 8'hA5;
    tk(3);
    chk({gen_ready, out_valid}, 2'b01);
    gen_valid <= 1'b0;
    out_ready <= 1'b1;
    tk(1);
    chk(last_q.level, 8'h5A);
    tk(1);
    chk({last_q.level, out_valid}, {8'hA5, 1'b0});
    wrap_up();
  end
endmodule : bsc_ctrl_tb_top
`default_nettype wire
